// [shared/thf_pkg.sv]
package thf_pkg;
	// Clock and one-second divider
	localparam int unsigned CLK_HZ    = 50_000_000;
	localparam int unsigned SEC_S     = 1;
	localparam int unsigned SEC_CYC   = CLK_HZ * SEC_S;

	// Register byte addresses
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_WSET = 8'h04;
	localparam logic [7:0] ADR_TSET = 8'h08;
	localparam logic [7:0] ADR_HON  = 8'h0c;
	localparam logic [7:0] ADR_STAT = 8'h10;

	// Control fields
	localparam int unsigned CTRL_HPRIO = 3;
	localparam int unsigned CTRL_SPRIO = 4;
	localparam logic [2:0]  MODE_OFF   = 3'h0;
	localparam logic [2:0]  MODE_HEAT  = 3'h1;
	localparam logic [2:0]  MODE_COOL  = 3'h2;
	localparam logic [2:0]  MODE_TANK  = 3'h3;
	localparam logic [2:0]  MODE_HT    = 3'h4;

	// Temperatures are signed, in half degrees C
	typedef logic signed [15:0] thf_temp_t;
	localparam logic [4:0] CTRL_RST    = 5'h00;
	localparam thf_temp_t  WSET_RST    = 16'sh0050;
	localparam thf_temp_t  TSET_RST    = 16'sh0064;
	localparam thf_temp_t  HON_RST     = 16'sh005a;
	localparam thf_temp_t  DT_HEAT_OFF = 16'sh0004;
	localparam thf_temp_t  DT_HEAT_ON  = 16'shfffa;
	localparam thf_temp_t  DT_COOL_OFF = 16'shfffd;
	localparam thf_temp_t  DT_COOL_ON  = 16'sh0006;
	localparam thf_temp_t  DT_TANK_ON  = 16'shfffc;
	localparam thf_temp_t  TANK_CAP    = 16'sh0066;
	localparam thf_temp_t  OUT_TANK    = 16'sh006a;
	localparam thf_temp_t  LIM_55      = 16'sh006e;
	localparam thf_temp_t  LIM_57      = 16'sh0072;

	// Hold times
	localparam int unsigned HOLD_MIN   = 3;
	localparam int unsigned HOLD_S     = HOLD_MIN * 60;
	localparam int unsigned TK_OFF_S   = 10;
	localparam int unsigned INLET_S    = 60;
	localparam int unsigned BST_HI_S   = 15;
	localparam int unsigned BST_GAP_MIN = 20;
	localparam int unsigned BST_GAP_S  = BST_GAP_MIN * 60;
	localparam int unsigned BST_DLY_S  = 60;

	// Timer slots
	localparam int unsigned TM_N    = 10;
	localparam int unsigned TM_W    = 11;
	localparam int unsigned TM_ROOM = 0;
	localparam int unsigned TM_C2   = 1;
	localparam int unsigned TM_C3   = 2;
	localparam int unsigned TM_WAIT = 3;
	localparam int unsigned TM_TK10 = 4;
	localparam int unsigned TM_TK3  = 5;
	localparam int unsigned TM_PRE  = 6;
	localparam int unsigned TM_BHI  = 7;
	localparam int unsigned TM_BGAP = 8;
	localparam int unsigned TM_BDLY = 9;
	localparam logic [10:0] TM_LIM [TM_N] = '{11'(HOLD_S), 11'(HOLD_S), 11'(INLET_S),
		11'(HOLD_S), 11'(TK_OFF_S), 11'(HOLD_S), 11'(HOLD_S), 11'(BST_HI_S),
		11'(BST_GAP_S), 11'(BST_DLY_S)};

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_RUN   = 4'h2,
		ST_THOFF = 4'h4,
		ST_PRE   = 4'h8
	} thf_state_t;

	localparam logic [1:0] RS_ROOM  = 2'h0;
	localparam logic [1:0] RS_C2    = 2'h1;
	localparam logic [1:0] RS_C3    = 2'h2;
	localparam logic [1:0] RS_WATER = 2'h3;
endpackage

// [src/thf_hold_timer.sv]
`timescale 1ns/1ps
module thf_hold_timer import thf_pkg::*; #(
	parameter int unsigned W = 11
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         tick_i,
	input  wire logic         run_i,
	input  wire logic [W-1:0] limit_i,
	output logic              done_o
);
	logic [W-1:0] cnt_q;

	// One extra tick so a partial first second never counts
	assign done_o = cnt_q > limit_i;

	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_q <= '0;
		end else if (tick_i && !done_o) begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	restart_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!run_i |=> !done_o)
		else $error("timer done without unbroken run");
endmodule

// [src/thf_thermostat.sv]
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module thf_thermostat import thf_pkg::*; #(
	parameter int unsigned SEC_CYCLES    = SEC_CYC,
	parameter int unsigned BOOST_DELAY_S = BST_DLY_S
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire thf_temp_t   outlet_temp_i,
	input  wire thf_temp_t   inlet_temp_i,
	input  wire thf_temp_t   tank_temp_i,
	input  wire logic        room_heat_i,
	input  wire logic        solar_req_i,
	output logic             comp_on_o,
	output logic             pump_on_o,
	output logic             booster_on_o,
	output logic             backup_en_o,
	output logic             diverter_tank_o,
	output logic             twoway_open_o,
	output logic             solar_valve_o,
	output thf_temp_t        outlet_set_o
);
	logic [4:0]      ctrl_q;
	thf_temp_t       wset_q, tset_q, hon_q, lat_q, oset_q;
	logic            ack_q;
	logic [31:0]     rdat_q, wr_old, wr_new;
	logic [25:0]     div_q;
	logic            tick_q;
	thf_state_t      st_q, st_d;
	logic [1:0]      rs_q, rs_d;
	logic            side_tank_q, comp_q, pump_q, boost_q, backup_q;
	logic            div_tank_q, tw_q, solar_q;
	logic [15:0]     ivl_q;
	logic [TM_N-1:0] tm_run, tm_done;
	logic [10:0]     tm_lim [TM_N];
	logic [2:0]      mode;
	logic            hprio, sprio, is_heat, is_cool, is_tank, is_ht, run_ok;
	logic            tank_side, tank_off, tank_on, ret_stop, wr_en;
	thf_temp_t       tank_cap, wset_eff;
	logic signed [16:0] d_set, d_lat;

	function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Wishbone slave: one wait state, unmapped reads zero and writes vanish
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

	always_comb begin
		case (wb_adr_i)
			ADR_CTRL: wr_old = {27'h0, ctrl_q};
			ADR_WSET: wr_old = {16'h0, wset_q};
			ADR_TSET: wr_old = {16'h0, tset_q};
			ADR_HON:  wr_old = {16'h0, hon_q};
			default:  wr_old = 32'h0;
		endcase
		wr_new = wmask(wr_old, wb_dat_i, wb_sel_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RST;
			wset_q <= WSET_RST;
			tset_q <= TSET_RST;
			hon_q  <= HON_RST;
		end else if (wr_en) begin
			case (wb_adr_i)
				ADR_CTRL: ctrl_q <= wr_new[4:0];
				ADR_WSET: wset_q <= wr_new[15:0];
				ADR_TSET: tset_q <= wr_new[15:0];
				ADR_HON:  hon_q  <= wr_new[15:0];
				default:  ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 32'h0;
		end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
			case (wb_adr_i)
				ADR_CTRL: rdat_q <= wr_old;
				ADR_WSET: rdat_q <= wr_old;
				ADR_TSET: rdat_q <= wr_old;
				ADR_HON:  rdat_q <= wr_old;
				ADR_STAT: rdat_q <= {ivl_q, 2'h0, rs_q, st_q, side_tank_q, solar_q, tw_q,
					div_tank_q, backup_q, boost_q, pump_q, comp_q};
				default:  rdat_q <= 32'h0;
			endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// One-second enable
	always_ff @(posedge clk_i) begin
		if (rst_i || div_q == 26'(SEC_CYCLES - 1)) begin
			div_q <= 26'h0;
		end else begin
			div_q <= div_q + 26'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= div_q == 26'(SEC_CYCLES - 1);
		end
	end

	// Mode decode and setpoints
	assign mode      = ctrl_q[2:0];
	assign hprio     = ctrl_q[CTRL_HPRIO];
	assign sprio     = ctrl_q[CTRL_SPRIO];
	assign is_heat   = mode == MODE_HEAT;
	assign is_cool   = mode == MODE_COOL;
	assign is_tank   = mode == MODE_TANK;
	assign is_ht     = mode == MODE_HT;
	assign tank_side = is_tank || (is_ht && side_tank_q);
	assign tank_cap  = (tset_q < TANK_CAP) ? tset_q : TANK_CAP;
	assign wset_eff  = tank_side ? tank_cap : wset_q;
	assign tank_off  = tank_temp_i > tank_cap;
	assign tank_on   = tank_temp_i < tank_cap + DT_TANK_ON;
	assign d_set     = 17'(outlet_temp_i) - 17'(wset_eff);
	assign d_lat     = 17'(outlet_temp_i) - 17'(lat_q);
	// Heating priority parks the pump on room side unless heat is requested
	assign run_ok    = is_heat || is_cool || is_tank ||
		(is_ht && (side_tank_q || !hprio || room_heat_i));
	assign ret_stop  = is_ht && hprio && side_tank_q &&
		(room_heat_i || tm_done[TM_TK3] || (sprio && solar_q));

	// Hold-time conditions
	always_comb begin
		tm_run[TM_ROOM] = st_q == ST_RUN && !tank_side &&
			(is_cool ? d_set > DT_COOL_OFF : d_set > DT_HEAT_OFF);
		tm_run[TM_C2]   = st_q == ST_RUN && tank_side && outlet_temp_i > LIM_57;
		tm_run[TM_C3]   = st_q == ST_RUN && tank_side && inlet_temp_i > LIM_55;
		tm_run[TM_WAIT] = st_q == ST_THOFF;
		tm_run[TM_TK10] = !comp_q && tank_side && tank_off;
		tm_run[TM_TK3]  = is_ht && hprio && side_tank_q && tank_off;
		tm_run[TM_PRE]  = st_q == ST_PRE;
		tm_run[TM_BHI]  = tank_temp_i > tset_q;
		tm_run[TM_BGAP] = !boost_q;
		tm_run[TM_BDLY] = is_tank || is_ht;
		tm_lim          = TM_LIM;
		tm_lim[TM_BDLY] = 11'(BOOST_DELAY_S);
	end

	for (genvar g = 0; g < TM_N; g++) begin : g_tmr
		thf_hold_timer #(
			.W(TM_W)
		) u_tmr (
			.clk_i  (clk_i),
			.rst_i  (rst_i),
			.tick_i (tick_q),
			.run_i  (tm_run[g]),
			.limit_i(tm_lim[g]),
			.done_o (tm_done[g])
		);
	end

	// Compressor sequencer
	always_comb begin
		st_d = st_q;
		rs_d = rs_q;
		case (st_q)
			ST_IDLE: begin
				if (run_ok && is_tank) begin
					if (tank_on) begin
						st_d = ST_PRE;
					end
				end else if (run_ok) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!run_ok || ret_stop) begin
					st_d = ST_IDLE;
				end else if (tm_done[TM_ROOM]) begin
					st_d = ST_THOFF;
					rs_d = RS_ROOM;
				end else if (tm_done[TM_C2]) begin
					st_d = ST_THOFF;
					rs_d = RS_C2;
				end else if (tm_done[TM_C3]) begin
					st_d = ST_THOFF;
					rs_d = RS_C3;
				end else if (tank_side && tank_off) begin
					st_d = ST_THOFF;
					rs_d = RS_WATER;
				end
			end
			ST_THOFF: begin
				if (!run_ok || ret_stop) begin
					st_d = ST_IDLE;
				end else begin
					case (rs_q)
						RS_ROOM: begin
							if (tm_done[TM_WAIT] &&
								d_lat < (is_cool ? DT_COOL_ON : DT_HEAT_ON)) begin
								st_d = ST_RUN;
							end
						end
						RS_C2: begin
							if (d_lat < DT_HEAT_ON) begin
								st_d = ST_RUN;
							end
						end
						RS_C3: begin
							if (inlet_temp_i < LIM_55) begin
								st_d = ST_RUN;
							end
						end
						default: begin
							if (!tank_side) begin
								st_d = ST_RUN;
							end else if (is_tank && tm_done[TM_TK10]) begin
								st_d = ST_IDLE;
							end
						end
					endcase
				end
			end
			ST_PRE: begin
				if (!run_ok) begin
					st_d = ST_IDLE;
				end else if (tm_done[TM_PRE]) begin
					st_d = ST_RUN;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q   <= ST_IDLE;
			rs_q   <= RS_ROOM;
			comp_q <= 1'b0;
			pump_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			rs_q   <= rs_d;
			comp_q <= st_d == ST_RUN;
			pump_q <= st_d != ST_IDLE;
		end
	end

	// Inlet is latched at the moment the compressor goes from run to thermo-off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lat_q <= 16'sh0000;
		end else if (st_q == ST_RUN && st_d == ST_THOFF) begin
			lat_q <= inlet_temp_i;
		end
	end

	// Room or tank side for heat plus tank
	always_ff @(posedge clk_i) begin
		if (rst_i || !is_ht) begin
			side_tank_q <= 1'b1;
		end else if (side_tank_q) begin
			if ((hprio && ret_stop) || tm_done[TM_TK10] || (sprio && solar_q)) begin
				side_tank_q <= 1'b0;
			end
		end else if (tank_on && !(sprio && solar_q) && !(hprio && room_heat_i)) begin
			side_tank_q <= 1'b1;
		end
	end

	// Interval timer restarts on each side change
	always_ff @(posedge clk_i) begin
		if (rst_i || (is_ht && side_tank_q != div_tank_q)) begin
			ivl_q <= 16'h0;
		end else if (tick_q && ivl_q != 16'hffff) begin
			ivl_q <= ivl_q + 16'h1;
		end
	end

	// Booster heater
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boost_q <= 1'b0;
		end else if (!(is_tank || is_ht) || (sprio && solar_q) || tm_done[TM_BHI]) begin
			boost_q <= 1'b0;
		end else if (tm_done[TM_BDLY] && tm_done[TM_BGAP] && tank_temp_i < hon_q) begin
			boost_q <= 1'b1;
		end
	end

	// Valves, backup permission and outlet setpoint
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			backup_q   <= 1'b0;
			div_tank_q <= 1'b0;
			tw_q       <= 1'b0;
			solar_q    <= 1'b0;
			oset_q     <= WSET_RST;
		end else begin
			backup_q   <= is_heat ||
				(is_ht && !side_tank_q && (!hprio || room_heat_i));
			div_tank_q <= tank_side;
			tw_q       <= is_heat || is_ht;
			solar_q    <= solar_req_i && mode != MODE_OFF &&
				!(!sprio && tank_side);
			oset_q     <= is_tank ? OUT_TANK : (tank_side ? LIM_55 : wset_q);
		end
	end

	assign comp_on_o       = comp_q;
	assign pump_on_o       = pump_q;
	assign booster_on_o    = boost_q;
	assign backup_en_o     = backup_q;
	assign diverter_tank_o = div_tank_q;
	assign twoway_open_o   = tw_q;
	assign solar_valve_o   = solar_q;
	assign outlet_set_o    = oset_q;

	cool_backup_a: assert property (@(posedge clk_i) disable iff (rst_i)
		is_cool [*2] |-> !backup_en_o && !diverter_tank_o && !twoway_open_o)
		else $error("cool mode valve or backup wrong");

	tank_valve_a: assert property (@(posedge clk_i) disable iff (rst_i)
		is_tank [*2] |-> diverter_tank_o && !twoway_open_o && !backup_en_o &&
			outlet_set_o == OUT_TANK)
		else $error("tank mode outputs wrong");

	prepump_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q == ST_PRE |-> pump_on_o && !comp_on_o)
		else $error("compressor ran during pre-pump");

	room_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(comp_on_o) && st_q == ST_THOFF && rs_q == RS_ROOM |-> $past(tm_done[TM_ROOM]))
		else $error("room thermo stop without 3 min hold");

	restart_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(comp_on_o) && $past(st_q == ST_THOFF && rs_q == RS_ROOM)
		|-> $past(tm_done[TM_WAIT]))
		else $error("restart before 3 min wait");

	inlet_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(comp_on_o) && st_q == ST_THOFF && rs_q == RS_C3 |-> $past(tm_done[TM_C3]))
		else $error("inlet stop without 60 s hold");

	boost_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(booster_on_o) |-> $past(tm_done[TM_BGAP]) && $past(tank_temp_i < hon_q))
		else $error("booster on too early");

	solar_boost_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sprio && solar_valve_o |=> !booster_on_o)
		else $error("booster on with solar valve");

	prio_backup_a: assert property (@(posedge clk_i) disable iff (rst_i)
		is_ht && hprio && !room_heat_i |=> !backup_en_o)
		else $error("backup on without room request");

	solar_side_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!sprio && tank_side |=> !solar_valve_o)
		else $error("solar valve on at tank side");
endmodule

// [tb/thf_plant.sv]
`timescale 1ns/1ps
module thf_plant import thf_pkg::*; (
	input  wire logic clk_i,
	output thf_temp_t outlet_o,
	output thf_temp_t inlet_o,
	output thf_temp_t tank_o,
	output logic      room_heat_o,
	output logic      solar_req_o
);
	// Sensors start in a quiet, hot-tank state so the tank calls for no heat at mode entry
	initial begin
		outlet_o = 16'sh0050;
		inlet_o = 16'sh0048;
		tank_o = 16'sh0070;
		room_heat_o = 1'b0;
		solar_req_o = 1'b0;
	end

	// New readings land just after an edge, never on it
	task automatic set_env(input thf_temp_t o, input thf_temp_t i, input thf_temp_t t,
		input logic r, input logic s);
		@(posedge clk_i);
		outlet_o <= o;
		inlet_o <= i;
		tank_o <= t;
		room_heat_o <= r;
		solar_req_o <= s;
	endtask
endmodule

// [tb/tb_tank_heat_thermostat_fsm.sv]
`timescale 1ns/1ps
module tb_tank_heat_thermostat_fsm import thf_pkg::*;;
	// Ten cycles a second keeps three-minute holds near 1800 cycles
	localparam int SC = 10;
	localparam int LIMIT = 20000;
	localparam logic [6:0] CMP = 7'h01, PMP = 7'h02, BST = 7'h04, BKP = 7'h08;
	localparam logic [6:0] DIV = 7'h10, TWO = 7'h20, SOL = 7'h40;
	localparam logic [7:0] RA [5] = '{ADR_CTRL, ADR_WSET, ADR_TSET, ADR_HON, 8'h20};
	localparam logic [31:0] RV [5] = '{32'(CTRL_RST), 32'(WSET_RST), 32'(TSET_RST),
		32'(HON_RST), 32'h0};

	logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd, lfsr_q;
	logic [3:0]  wb_sel_i;
	logic [15:0] ws;
	thf_temp_t   outlet_t, inlet_t, tank_t, outlet_set_o;
	logic        room_w, solar_w, comp_on_o, pump_on_o, booster_on_o, backup_en_o;
	logic        diverter_tank_o, twoway_open_o, solar_valve_o;
	logic [6:0]  outs;
	int          miscompares = 0, num_checks = 0, cyc_cnt = 0;

	assign outs = {solar_valve_o, twoway_open_o, diverter_tank_o, backup_en_o,
		booster_on_o, pump_on_o, comp_on_o};

	thf_plant u_plant (.clk_i(clk_i), .outlet_o(outlet_t), .inlet_o(inlet_t),
		.tank_o(tank_t), .room_heat_o(room_w), .solar_req_o(solar_w));

	thf_thermostat #(.SEC_CYCLES(SC), .BOOST_DELAY_S(5)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.outlet_temp_i(outlet_t), .inlet_temp_i(inlet_t), .tank_temp_i(tank_t),
		.room_heat_i(room_w), .solar_req_i(solar_w), .comp_on_o(comp_on_o),
		.pump_on_o(pump_on_o), .booster_on_o(booster_on_o), .backup_en_o(backup_en_o),
		.diverter_tank_o(diverter_tank_o), .twoway_open_o(twoway_open_o),
		.solar_valve_o(solar_valve_o), .outlet_set_o(outlet_set_o));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// Byte-lane merge of a write into a 16-bit setting
	function automatic logic [15:0] lane_mix(input logic [15:0] o, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction

	task automatic finish_test();
		if (miscompares == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// A hang in any wait still ends in the one closing report
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == LIMIT) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_o(input logic [6:0] m, input logic [6:0] e, input string msg);
		chk(32'(outs & m), 32'(e), msg);
	endtask

	// Classic cycle: hold everything until ack is sampled, then release
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		// No latency assumed while waiting; only the bench timeout ends a hang
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		chk(32'(n), 32'h2, "ack latency");
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// Counts cycles until the masked outputs reach v, then checks the window
	task automatic wait_bit(input logic [6:0] m, input logic v, input int lo, input int hi);
		int n;
		n = 0;
		while (((outs & m) != 7'h0) !== v && n <= hi) begin
			@(posedge clk_i);
			n++;
		end
		chk(32'(n >= lo && n <= hi), 32'h1, "output delay");
	endtask

	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'h0;
		lfsr_q = 32'h00015044;
		ws = 16'h0050;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_o(7'h7f, 7'h00, "reset outputs");
		chk(32'(outlet_set_o), 32'(WSET_RST), "reset setpoint");
		for (int k = 0; k < 5; k++) begin
			wb(1'b0, RA[k], 32'h0, 4'hf);
			chk(rd, RV[k], "register reset");
		end
		// Byte lanes honoured; upper lanes read back as zero
		for (int k = 0; k < 6; k++) begin
			lfsr_q = lfsr_next(lfsr_q);
			wb(1'b1, ADR_WSET, lfsr_q, lfsr_q[3:0]);
			ws = lane_mix(ws, lfsr_q, lfsr_q[3:0]);
			wb(1'b0, ADR_WSET, 32'h0, 4'hf);
			chk(rd, {16'h0, ws}, "wset lanes");
		end
		wb(1'b1, ADR_WSET, 32'h50, 4'hf);
		wb(1'b1, ADR_CTRL, 32'hffffffff, 4'hf);
		wb(1'b0, ADR_CTRL, 32'h0, 4'hf);
		chk(rd, 32'h1f, "ctrl width");
		wb(1'b1, ADR_CTRL, 32'h0, 4'hf);
		// Heating: a broken hold restarts, the full hold stops, latched inlet restarts
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh0070, 1'b1, 1'b0);
		wb(1'b1, ADR_CTRL, 32'h1, 4'hf);
		repeat (3) @(posedge clk_i);
		chk_o(CMP | PMP | TWO | DIV | BKP, CMP | PMP | TWO | BKP, "heat entry");
		u_plant.set_env(16'sh0055, 16'sh0048, 16'sh0070, 1'b1, 1'b0);
		repeat (1000) @(posedge clk_i);
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh0070, 1'b1, 1'b0);
		repeat (20) @(posedge clk_i);
		chk_o(CMP, CMP, "early stop");
		lfsr_q = lfsr_next(lfsr_q);
		u_plant.set_env(16'sh0055 + thf_temp_t'(lfsr_q[2:0]), 16'sh0048, 16'sh0070, 1'b1, 1'b0);
		wait_bit(CMP, 1'b0, 1795, 1840);
		chk_o(PMP, PMP, "pump kept");
		// Current inlet would not qualify; only the latched one does
		u_plant.set_env(16'sh0041, 16'sh0030, 16'sh0070, 1'b1, 1'b0);
		wait_bit(CMP, 1'b1, 1770, 1850);
		// Cooling
		u_plant.set_env(16'sh004e, 16'sh0048, 16'sh0070, 1'b0, 1'b0);
		wb(1'b1, ADR_CTRL, 32'h2, 4'hf);
		repeat (3) @(posedge clk_i);
		chk_o(CMP | DIV | TWO | BKP, CMP, "cool entry");
		wait_bit(CMP, 1'b0, 1795, 1840);
		chk_o(BKP | DIV, 7'h00, "cool backup");
		// Tank only, with a tank setting above the 51C cap
		// Off first so a cooling thermo-off is not carried into tank mode
		wb(1'b1, ADR_CTRL, 32'h0, 4'hf);
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh0070, 1'b0, 1'b0);
		wb(1'b1, ADR_TSET, 32'h70, 4'hf);
		wb(1'b1, ADR_CTRL, 32'h3, 4'hf);
		repeat (3) @(posedge clk_i);
		chk_o(CMP | DIV | TWO | BKP, DIV, "tank entry");
		chk(32'(outlet_set_o), 32'(OUT_TANK), "tank outlet set");
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh0061, 1'b0, 1'b0);
		wait_bit(PMP, 1'b1, 0, 5);
		chk_o(CMP, 7'h00, "pre pump");
		wait_bit(CMP, 1'b1, 1790, 1840);
		u_plant.set_env(16'sh0050, 16'sh006f, 16'sh0061, 1'b0, 1'b0);
		wait_bit(CMP, 1'b0, 595, 640);
		u_plant.set_env(16'sh0050, 16'sh006d, 16'sh0061, 1'b0, 1'b0);
		wait_bit(CMP, 1'b1, 0, 20);
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh0067, 1'b0, 1'b0);
		wait_bit(CMP, 1'b0, 0, 5);
		wait_bit(PMP, 1'b0, 95, 140);
		// Heat plus tank with heating priority
		wb(1'b1, ADR_TSET, 32'h64, 4'hf);
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh005f, 1'b1, 1'b0);
		wb(1'b1, ADR_CTRL, 32'h0c, 4'hf);
		repeat (4) @(posedge clk_i);
		chk_o(DIV | BKP, BKP, "prio room");
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh005f, 1'b0, 1'b0);
		repeat (3) @(posedge clk_i);
		chk_o(DIV | BKP, DIV, "prio tank");
		chk(32'(outlet_set_o), 32'(LIM_55), "interval outlet set");
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh005f, 1'b1, 1'b0);
		repeat (3) @(posedge clk_i);
		chk_o(DIV, 7'h00, "room again");
		wb(1'b1, ADR_CTRL, 32'h1c, 4'hf);
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh005f, 1'b0, 1'b1);
		repeat (4) @(posedge clk_i);
		chk_o(SOL | DIV | BST, SOL, "solar prio");
		// No heating priority: tank interval first, solar valve shut there
		wb(1'b1, ADR_CTRL, 32'h0, 4'hf);
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh005f, 1'b1, 1'b1);
		wb(1'b1, ADR_CTRL, 32'h4, 4'hf);
		repeat (3) @(posedge clk_i);
		chk_o(DIV | SOL, DIV, "no prio start");
		// Booster waits out its off gap counted from reset, then a hot tank ends it
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh0058, 1'b1, 1'b1);
		wait_bit(BST, 1'b1, int'(BST_GAP_S) * SC - cyc_cnt,
			int'(BST_GAP_S) * SC + 40 - cyc_cnt);
		u_plant.set_env(16'sh0050, 16'sh0048, 16'sh0066, 1'b1, 1'b1);
		wait_bit(BST, 1'b0, 150, 175);
		finish_test();
	end
endmodule
